// ==== cpu_fetch_sequencer.sv ====
// What this block does
// - 24-bit word, top byte is opcode
// - three opcodes span two words, 48 bits
// - second word has zero top byte, NOP alone
// - one cycle, two when condition or PC changes
// - jumps, table ops, returns take two/three cycles
// - taken skip: two or three cycles by size
// - double-word moves and two-word ops: two cycles
// - three-operand: plain base, modified source and dest
// - file ops: address plus file-or-default destination
// - bit select by literal or register
// - literal ops: base, literal, optional dest
//
// instruction fetch, split and cycle sequencing for the core
// assumes program memory offers words with valid/ready, and that after
// pc_load_o exactly one word of the old stream is accepted
`timescale 1ns/100ps
module cpu_fetch_sequencer (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [23:0] instr_i,
    input wire logic instr_valid_i,
    output logic instr_ready_o,
    input wire logic cond_true_i,
    output logic issue_valid_o,
    output logic issue_nop_o,
    output logic issue_second_o,
    output logic [7:0] opcode_o,
    output cpu_fmt_pkg::instr_class_t class_o,
    output logic [3:0] base_source_operand_o,
    output logic [3:0] second_source_operand_o,
    output logic [1:0] second_mode_o,
    output logic [3:0] dest_operand_o,
    output logic [1:0] dest_mode_o,
    output logic [12:0] file_addr_o,
    output logic default_working_reg_o,
    output logic [3:0] bit_sel_o,
    output logic bit_from_reg_o,
    output logic [15:0] literal_o,
    output logic [23:0] ext_word_o,
    output logic pc_load_o
);
    // split of the word on offer
    cpu_fmt_pkg::instr_class_t d_cls;
    logic [3:0] d_base, d_src, d_dest, d_bit;
    logic [1:0] d_smode, d_dmode;
    logic [12:0] d_faddr;
    logic d_dflt, d_bitreg;
    logic [15:0] d_lit;

    // sequencer state
    cpu_fmt_pkg::seq_state_t state_q; // first or second word expected
    logic [1:0] stall_q; // cycles with no word taken
    logic [1:0] squash_q; // words still to discard
    logic skip_sq_q; // pending discard comes from a skip

    // issue registers
    logic issue_valid_q, issue_nop_q, issue_second_q;
    logic [7:0] opcode_q;
    cpu_fmt_pkg::instr_class_t class_q;
    logic [3:0] base_q, src_q, dest_q, bit_q;
    logic [1:0] smode_q, dmode_q;
    logic [12:0] faddr_q;
    logic dflt_q, bitreg_q;
    logic [15:0] lit_q;
    logic [23:0] ext_q;

    // per-cycle decisions
    logic accept; // word taken this cycle
    logic cond_taken; // shown conditional resolved true
    logic discard; // taken word is thrown away
    logic skip_mode; // discard belongs to a skip
    logic normal; // taken word starts an instruction
    logic second; // taken word is the second of a pair
    logic two_next; // offered word starts a pair

    instr_field_split u_split (
        .word_i(instr_i),
        .cls_o(d_cls),
        .base_o(d_base),
        .src_o(d_src),
        .smode_o(d_smode),
        .dest_o(d_dest),
        .dmode_o(d_dmode),
        .file_addr_o(d_faddr),
        .dest_default_o(d_dflt),
        .bit_sel_o(d_bit),
        .bit_from_reg_o(d_bitreg),
        .lit_o(d_lit)
    );

    // handshake and decisions
    assign instr_ready_o = (stall_q == 2'h0);
    assign accept = instr_valid_i & instr_ready_o;
    assign cond_taken = issue_valid_q & ~issue_nop_q & cond_true_i &
                        (class_q == cpu_fmt_pkg::CLS_COND_BR || class_q == cpu_fmt_pkg::CLS_SKIP);
    assign discard = accept & ((squash_q != 2'h0) | cond_taken);
    assign skip_mode = cond_taken ? (class_q == cpu_fmt_pkg::CLS_SKIP) : skip_sq_q;
    assign normal = accept & ~discard & (state_q == cpu_fmt_pkg::ST_ISSUE);
    assign second = accept & ~discard & (state_q == cpu_fmt_pkg::ST_WORD2);
    assign two_next = (d_cls == cpu_fmt_pkg::CLS_TWO_WORD);

    // redirect: taken branch now, or shown jump/return
    assign pc_load_o = (cond_taken & (class_q == cpu_fmt_pkg::CLS_COND_BR)) |
                       (issue_valid_q & ~issue_nop_q & (class_q == cpu_fmt_pkg::CLS_PC_JUMP ||
                        class_q == cpu_fmt_pkg::CLS_RETURN));

    // first/second word tracking
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= cpu_fmt_pkg::ST_ISSUE;
        end else if (normal && two_next) begin
            state_q <= cpu_fmt_pkg::ST_WORD2;
        end else if (second) begin
            state_q <= cpu_fmt_pkg::ST_ISSUE;
        end
    end

    // stall cycles that take no word
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stall_q <= 2'h0;
        end else if (normal && d_cls == cpu_fmt_pkg::CLS_RETURN) begin
            stall_q <= cpu_fmt_pkg::STALL_RETURN;
        end else if (normal && (d_cls == cpu_fmt_pkg::CLS_TABLE || d_cls == cpu_fmt_pkg::CLS_DW_MOVE)) begin
            stall_q <= cpu_fmt_pkg::STALL_TABLE;
        end else if (stall_q != 2'h0) begin
            stall_q <= stall_q - 2'h1;
        end
    end

    // words to discard after a PC change or taken skip
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            squash_q <= 2'h0;
            skip_sq_q <= 1'b0;
        end else if (normal && (d_cls == cpu_fmt_pkg::CLS_PC_JUMP || d_cls == cpu_fmt_pkg::CLS_RETURN)) begin
            squash_q <= cpu_fmt_pkg::SQUASH_PC;
            skip_sq_q <= 1'b0;
        end else if (discard) begin
            // a skipped pair costs one more discard
            if (skip_mode && two_next) begin
                squash_q <= cpu_fmt_pkg::SQUASH_PC;
            end else if (squash_q != 2'h0) begin
                squash_q <= squash_q - 2'h1;
            end else begin
                squash_q <= cpu_fmt_pkg::SQUASH_NONE;
            end
            skip_sq_q <= 1'b0;
        end else if (cond_taken) begin
            // nothing on offer yet: discard the next word
            squash_q <= cpu_fmt_pkg::SQUASH_PC;
            skip_sq_q <= (class_q == cpu_fmt_pkg::CLS_SKIP);
        end
    end

    // issue strobe and NOP marking, one per instruction cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            issue_valid_q <= 1'b0;
            issue_nop_q <= 1'b0;
            issue_second_q <= 1'b0;
        end else begin
            issue_valid_q <= normal | second | discard | (stall_q != 2'h0);
            issue_nop_q <= discard | (stall_q != 2'h0);
            issue_second_q <= second;
        end
    end

    // operand fields, loaded by a first word only
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            opcode_q <= 8'h00;
            class_q <= cpu_fmt_pkg::CLS_NOP;
            base_q <= 4'h0;
            src_q <= 4'h0;
            smode_q <= 2'h0;
            dest_q <= 4'h0;
            dmode_q <= 2'h0;
            faddr_q <= 13'h0000;
            dflt_q <= 1'b0;
            bit_q <= 4'h0;
            bitreg_q <= 1'b0;
            lit_q <= 16'h0000;
        end else if (normal) begin
            opcode_q <= instr_i[cpu_fmt_pkg::OPC_LSB +: cpu_fmt_pkg::OPC_W];
            class_q <= d_cls;
            base_q <= d_base;
            src_q <= d_src;
            smode_q <= d_smode;
            dest_q <= d_dest;
            dmode_q <= d_dmode;
            faddr_q <= d_faddr;
            dflt_q <= d_dflt;
            bit_q <= d_bit;
            bitreg_q <= d_bitreg;
            lit_q <= d_lit;
        end
    end

    // extension word of a pair
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_q <= 24'h000000;
        end else if (second) begin
            ext_q <= instr_i;
        end
    end

    // outputs
    assign issue_valid_o = issue_valid_q;
    assign issue_nop_o = issue_nop_q;
    assign issue_second_o = issue_second_q;
    assign opcode_o = opcode_q;
    assign class_o = class_q;
    assign base_source_operand_o = base_q;
    assign second_source_operand_o = src_q;
    assign second_mode_o = smode_q;
    assign dest_operand_o = dest_q;
    assign dest_mode_o = dmode_q;
    assign file_addr_o = faddr_q;
    assign default_working_reg_o = dflt_q;
    assign bit_sel_o = bit_q;
    assign bit_from_reg_o = bitreg_q;
    assign literal_o = lit_q;
    assign ext_word_o = ext_q;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // first word of an instruction shown
    logic shown_first;
    assign shown_first = issue_valid_q & ~issue_nop_q & ~issue_second_q;

    chk_opcode_top_byte: assert property (normal |=> opcode_o == $past(instr_i[23:16]))
        else $error("opcode not taken from top byte");
    chk_pair_second: assert property (normal && two_next |-> ##[1:64] (issue_second_o && !issue_nop_o))
        else $error("second word of pair never issued");
    chk_zero_is_nop: assert property (shown_first && opcode_o == 8'h00 |-> class_o == cpu_fmt_pkg::CLS_NOP
                                      && !pc_load_o && instr_ready_o)
        else $error("zero opcode not a plain NOP");
    chk_branch_flush: assert property (cond_taken && class_o == cpu_fmt_pkg::CLS_COND_BR |-> pc_load_o
                                       ##1 (squash_q == 2'h1 || issue_nop_o))
        else $error("taken branch did not redirect and discard");
    chk_return_three: assert property (shown_first && class_o == cpu_fmt_pkg::CLS_RETURN |-> pc_load_o
                                       && !instr_ready_o ##1 (issue_valid_o && issue_nop_o && squash_q == 2'h1))
        else $error("return did not stall and discard");
    chk_skip_pair: assert property (discard && skip_mode && two_next |=> squash_q == 2'h1 && issue_nop_o)
        else $error("skipped pair not fully discarded");
    chk_table_two: assert property (shown_first && (class_o == cpu_fmt_pkg::CLS_TABLE ||
                                    class_o == cpu_fmt_pkg::CLS_DW_MOVE) |-> !instr_ready_o ##1 instr_ready_o)
        else $error("table or double move not exactly one stall");
    chk_three_operands: assert property (normal && d_cls == cpu_fmt_pkg::CLS_THREE_OP |=>
                                         base_source_operand_o == $past(instr_i[15:12]) &&
                                         dest_operand_o == $past(instr_i[9:6]))
        else $error("three-operand fields wrong");
    chk_file_dest: assert property (normal && d_cls == cpu_fmt_pkg::CLS_FILE |=>
                                    default_working_reg_o == !$past(instr_i[13]))
        else $error("file destination select wrong");
    chk_bit_source: assert property (shown_first && class_o == cpu_fmt_pkg::CLS_BIT |->
                                     bit_from_reg_o == opcode_o[1] && (opcode_o[1] ? bit_sel_o == 4'h0 : 1'b1))
        else $error("bit source select wrong");
    chk_lit_dest: assert property (shown_first && class_o == cpu_fmt_pkg::CLS_LIT_ARITH && !opcode_o[0] |->
                                   dest_operand_o == base_source_operand_o && dest_mode_o == 2'h0)
        else $error("literal op destination not the base");
    chk_squash_nop: assert property (accept && squash_q != 2'h0 |=> issue_valid_o && issue_nop_o)
        else $error("discarded word not issued as NOP");

    cov_pair: cover property (issue_second_o);
    cov_skip_pair: cover property (discard && skip_mode && two_next);
    cov_return: cover property (shown_first && class_o == cpu_fmt_pkg::CLS_RETURN);
    cov_branch_taken: cover property (cond_taken && class_o == cpu_fmt_pkg::CLS_COND_BR);
endmodule

// ==== cpu_fmt_pkg.sv ====
// constants and types shared by the instruction sequencer and its field splitter
// assumes a 24-bit program word with the opcode in the top byte
package cpu_fmt_pkg;
    // word and field widths
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_LSB = 16;
    // operand field positions inside the low 16 bits
    localparam int BASE_LSB = 12;
    localparam int DMODE_LSB = 10;
    localparam int DEST_LSB = 6;
    localparam int SMODE_LSB = 4;
    localparam int SRC_LSB = 0;
    localparam int FDEST_BIT = 13;
    localparam int FADDR_W = 13;
    localparam int LIT5_W = 5;
    // exact opcodes
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_CALC_JUMP = 8'h01;
    localparam logic [7:0] OPC_FAR_CALL = 8'h02;
    localparam logic [7:0] OPC_IND_CALL = 8'h03;
    localparam logic [7:0] OPC_FAR_JUMP = 8'h04;
    localparam logic [7:0] OPC_RETURN = 8'h06;
    localparam logic [7:0] OPC_INT_RETURN = 8'h07;
    localparam logic [7:0] OPC_FAR_LOAD = 8'h08;
    localparam logic [7:0] OPC_JUMP = 8'h37;
    localparam logic [7:0] OPC_TBL_RD = 8'hba;
    localparam logic [7:0] OPC_TBL_WR = 8'hbb;
    localparam logic [7:0] OPC_DW_MOVE = 8'hbe;
    // opcode group prefixes
    localparam logic [3:0] PFX_COND_BR = 4'h3;
    localparam logic [5:0] PFX_BIT = 6'h28;
    localparam logic [5:0] PFX_SKIP = 6'h29;
    localparam logic [1:0] PFX_THREE_OP = 2'h1;
    localparam logic [4:0] PFX_LIT = 5'h16;
    localparam logic [2:0] PFX_FILE = 3'h6;
    // extra cycle counts
    localparam logic [1:0] STALL_RETURN = 2'h1;
    localparam logic [1:0] STALL_TABLE = 2'h1;
    localparam logic [1:0] SQUASH_PC = 2'h1;
    localparam logic [1:0] SQUASH_NONE = 2'h0;
    // instruction groups
    typedef enum logic [3:0] {
        CLS_NOP, CLS_TWO_WORD, CLS_PC_JUMP, CLS_RETURN, CLS_TABLE, CLS_DW_MOVE,
        CLS_COND_BR, CLS_SKIP, CLS_BIT, CLS_THREE_OP, CLS_LIT_ARITH, CLS_FILE, CLS_OTHER
    } instr_class_t;
    // sequencer states
    typedef enum logic {ST_ISSUE, ST_WORD2} seq_state_t;
endpackage

// ==== instr_field_split.sv ====
// combinational split of one program word into group and operand fields
// assumes the word is stable while it is presented
`timescale 1ns/100ps
module instr_field_split (
    input wire logic [23:0] word_i,
    output cpu_fmt_pkg::instr_class_t cls_o,
    output logic [3:0] base_o,
    output logic [3:0] src_o,
    output logic [1:0] smode_o,
    output logic [3:0] dest_o,
    output logic [1:0] dmode_o,
    output logic [12:0] file_addr_o,
    output logic dest_default_o,
    output logic [3:0] bit_sel_o,
    output logic bit_from_reg_o,
    output logic [15:0] lit_o
);
    logic [7:0] op; // opcode byte
    logic [3:0] bit_field; // bit literal or bit register number
    assign op = word_i[cpu_fmt_pkg::OPC_LSB +: cpu_fmt_pkg::OPC_W];
    assign bit_field = op[0] ? {word_i[15:13], word_i[0]} : word_i[cpu_fmt_pkg::BASE_LSB +: 4];

    // group from the opcode byte
    always_comb begin
        if (op == cpu_fmt_pkg::OPC_NOP) begin
            cls_o = cpu_fmt_pkg::CLS_NOP;
        end else if (op == cpu_fmt_pkg::OPC_FAR_CALL || op == cpu_fmt_pkg::OPC_FAR_JUMP ||
                     op == cpu_fmt_pkg::OPC_FAR_LOAD) begin
            cls_o = cpu_fmt_pkg::CLS_TWO_WORD;
        end else if (op == cpu_fmt_pkg::OPC_JUMP || op == cpu_fmt_pkg::OPC_CALC_JUMP ||
                     op == cpu_fmt_pkg::OPC_IND_CALL) begin
            cls_o = cpu_fmt_pkg::CLS_PC_JUMP;
        end else if (op == cpu_fmt_pkg::OPC_RETURN || op == cpu_fmt_pkg::OPC_INT_RETURN) begin
            cls_o = cpu_fmt_pkg::CLS_RETURN;
        end else if (op == cpu_fmt_pkg::OPC_TBL_RD || op == cpu_fmt_pkg::OPC_TBL_WR) begin
            cls_o = cpu_fmt_pkg::CLS_TABLE;
        end else if (op == cpu_fmt_pkg::OPC_DW_MOVE) begin
            cls_o = cpu_fmt_pkg::CLS_DW_MOVE;
        end else if (op[7:4] == cpu_fmt_pkg::PFX_COND_BR) begin
            cls_o = cpu_fmt_pkg::CLS_COND_BR;
        end else if (op[7:2] == cpu_fmt_pkg::PFX_SKIP) begin
            cls_o = cpu_fmt_pkg::CLS_SKIP;
        end else if (op[7:2] == cpu_fmt_pkg::PFX_BIT) begin
            cls_o = cpu_fmt_pkg::CLS_BIT;
        end else if (op[7:6] == cpu_fmt_pkg::PFX_THREE_OP) begin
            cls_o = cpu_fmt_pkg::CLS_THREE_OP;
        end else if (op[7:3] == cpu_fmt_pkg::PFX_LIT) begin
            cls_o = cpu_fmt_pkg::CLS_LIT_ARITH;
        end else if (op[7:5] == cpu_fmt_pkg::PFX_FILE) begin
            cls_o = cpu_fmt_pkg::CLS_FILE;
        end else begin
            cls_o = cpu_fmt_pkg::CLS_OTHER;
        end
    end

    // operand fields, raw layout unless the group reshapes them
    always_comb begin
        base_o = word_i[cpu_fmt_pkg::BASE_LSB +: 4];
        src_o = word_i[cpu_fmt_pkg::SRC_LSB +: 4];
        smode_o = word_i[cpu_fmt_pkg::SMODE_LSB +: 2];
        dest_o = word_i[cpu_fmt_pkg::DEST_LSB +: 4];
        dmode_o = word_i[cpu_fmt_pkg::DMODE_LSB +: 2];
        file_addr_o = word_i[cpu_fmt_pkg::FADDR_W-1:0];
        dest_default_o = ~word_i[cpu_fmt_pkg::FDEST_BIT];
        bit_sel_o = 4'h0;
        bit_from_reg_o = 1'b0;
        lit_o = word_i[15:0];
        case (cls_o)
            cpu_fmt_pkg::CLS_BIT, cpu_fmt_pkg::CLS_SKIP: begin
                // target is a file register when op[0], else a working register
                if (op[0]) begin
                    file_addr_o = {word_i[12:1], 1'b0};
                end
                bit_from_reg_o = op[1];
                base_o = bit_field;
                bit_sel_o = op[1] ? 4'h0 : bit_field;
            end
            cpu_fmt_pkg::CLS_LIT_ARITH: begin
                // short literal as second source, own dest only when op[0]
                lit_o = {11'h000, word_i[cpu_fmt_pkg::LIT5_W-1:0]};
                src_o = 4'h0;
                smode_o = 2'h0;
                if (!op[0]) begin
                    dest_o = word_i[cpu_fmt_pkg::BASE_LSB +: 4];
                    dmode_o = 2'h0;
                end
            end
            default: begin
                // raw layout stands
            end
        endcase
    end
endmodule

// ==== prog_mem_model.sv ====
// program memory model: offers queued words to the fetch port with valid/ready
// assumes the bench pushes words in program order, target stream after redirects
`timescale 1ns/100ps
module prog_mem_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic push_i,
    input wire logic [23:0] push_word_i,
    input wire logic slow_i,
    input wire logic instr_ready_i,
    output logic [23:0] instr_o,
    output logic instr_valid_o,
    output logic empty_o
);
    logic [23:0] q[$]; // words not yet taken, head is on offer
    logic go; // offer the head this cycle
    assign empty_o = (q.size() == 0);
    // offer held until taken; idle bus inverts its last value every cycle
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            instr_valid_o <= 1'b0;
            instr_o <= 24'h000000;
        end else begin
            if (push_i) q.push_back(push_word_i);
            if (instr_valid_o && instr_ready_i) void'(q.pop_front());
            // new decision only when nothing is pending on the port
            if (!instr_valid_o || instr_ready_i) begin
                go = (q.size() > 0) && !(slow_i && ($urandom_range(1) == 1));
                instr_valid_o <= go;
                instr_o <= go ? q[0] : ~instr_o;
            end
        end
    end
endmodule

// ==== test_cpu_fetch_sequencer.sv ====
// self-checking bench for the fetch sequencer, driver notes issue cycles in a queue
// assumes the memory model in prog_mem_model.sv on the fetch port
`timescale 1ns/100ps
module test_cpu_fetch_sequencer;
    typedef struct {logic nop; logic sec; logic [23:0] w;} note_t;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic push_i = 1'b0;
    logic slow_i = 1'b0;
    logic cond_true_i = 1'b0;
    logic [23:0] push_word_i = 24'h000000;
    logic [23:0] instr_i;
    logic instr_valid_i, instr_ready_o, empty_o, pc_load_o;
    logic issue_valid_o, issue_nop_o, issue_second_o, default_working_reg_o, bit_from_reg_o;
    logic [7:0] opcode_o;
    cpu_fmt_pkg::instr_class_t class_o;
    logic [3:0] base_source_operand_o, second_source_operand_o, dest_operand_o, bit_sel_o;
    logic [1:0] second_mode_o, dest_mode_o;
    logic [12:0] file_addr_o;
    logic [15:0] literal_o;
    logic [23:0] ext_word_o;
    note_t exq[$]; // expected issue cycles, oldest first
    note_t e; // note under comparison
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int discard = 0; // words still to be thrown away
    logic skipf = 1'b0; // discard comes from a taken skip
    logic pairp = 1'b0; // next word is a second word
    logic pairw = 1'b0; // generator: next random word is a second word
    logic [23:0] w;
    logic [23:0] prog[26] = '{24'h000000, 24'h021234, 24'h005678, 24'h010000, 24'h00aaaa, 24'h03aaaa,
        24'h000000, 24'h041111, 24'h002222, 24'h060000, 24'h000000, 24'h070000, 24'h083333,
        24'h004444, 24'h370000, 24'h000000, 24'hba0000, 24'hbb0000, 24'hbe0000, 24'h351111,
        24'h000001, 24'ha59999, 24'h021111, 24'h002222, 24'h45a5c3, 24'hb3e01f};
    logic [23:0] tail[6] = '{24'hb2e01f, 24'hc82abc, 24'hc80123, 24'ha0f00f, 24'ha3f00f, 24'hea2001};
    // clock, 50 ns period
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    cpu_fetch_sequencer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .cond_true_i(cond_true_i),
        .issue_valid_o(issue_valid_o), .issue_nop_o(issue_nop_o), .issue_second_o(issue_second_o),
        .opcode_o(opcode_o), .class_o(class_o), .base_source_operand_o(base_source_operand_o),
        .second_source_operand_o(second_source_operand_o), .second_mode_o(second_mode_o),
        .dest_operand_o(dest_operand_o), .dest_mode_o(dest_mode_o), .file_addr_o(file_addr_o),
        .default_working_reg_o(default_working_reg_o), .bit_sel_o(bit_sel_o),
        .bit_from_reg_o(bit_from_reg_o), .literal_o(literal_o), .ext_word_o(ext_word_o),
        .pc_load_o(pc_load_o));
    prog_mem_model mem (.clk_i(clk_i), .rst_b_i(rst_b_i), .push_i(push_i), .push_word_i(push_word_i),
        .slow_i(slow_i), .instr_ready_i(instr_ready_o), .instr_o(instr_i),
        .instr_valid_o(instr_valid_i), .empty_o(empty_o));
    // closing verdict
    task results();
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one comparison
    task check(string nm, logic [23:0] seen, logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // instruction group of an opcode
    function automatic cpu_fmt_pkg::instr_class_t cls(logic [7:0] o);
        if (o == 8'h00) return cpu_fmt_pkg::CLS_NOP;
        if (o == 8'h02 || o == 8'h04 || o == 8'h08) return cpu_fmt_pkg::CLS_TWO_WORD;
        if (o == 8'h01 || o == 8'h03 || o == 8'h37) return cpu_fmt_pkg::CLS_PC_JUMP;
        if (o == 8'h06 || o == 8'h07) return cpu_fmt_pkg::CLS_RETURN;
        if (o == 8'hba || o == 8'hbb) return cpu_fmt_pkg::CLS_TABLE;
        if (o == 8'hbe) return cpu_fmt_pkg::CLS_DW_MOVE;
        if (o[7:4] == 4'h3) return cpu_fmt_pkg::CLS_COND_BR;
        if (o[7:2] == 6'h28) return cpu_fmt_pkg::CLS_BIT;
        if (o[7:2] == 6'h29) return cpu_fmt_pkg::CLS_SKIP;
        if (o[7:6] == 2'h1) return cpu_fmt_pkg::CLS_THREE_OP;
        if (o[7:3] == 5'h16) return cpu_fmt_pkg::CLS_LIT_ARITH;
        if (o[7:5] == 3'h6) return cpu_fmt_pkg::CLS_FILE;
        return cpu_fmt_pkg::CLS_OTHER;
    endfunction
    // hand one word to memory and note the issue cycles it must cause
    task push(logic [23:0] wd);
        push_i <= 1'b1;
        push_word_i <= wd;
        @(posedge clk_i);
        if (discard > 0) begin
            exq.push_back('{1'b1, 1'b0, wd});
            discard--;
            // a skipped pair loses its second word too
            if (skipf && cls(wd[23:16]) == cpu_fmt_pkg::CLS_TWO_WORD) discard = 1;
            else skipf = 1'b0;
        end else if (pairp) begin
            exq.push_back('{1'b0, 1'b1, wd});
            pairp = 1'b0;
        end else begin
            exq.push_back('{1'b0, 1'b0, wd});
            case (cls(wd[23:16]))
                cpu_fmt_pkg::CLS_TWO_WORD: pairp = 1'b1;
                cpu_fmt_pkg::CLS_PC_JUMP: discard = 1;
                cpu_fmt_pkg::CLS_RETURN: begin
                    exq.push_back('{1'b1, 1'b0, wd});
                    discard = 1;
                end
                cpu_fmt_pkg::CLS_TABLE, cpu_fmt_pkg::CLS_DW_MOVE: exq.push_back('{1'b1, 1'b0, wd});
                cpu_fmt_pkg::CLS_COND_BR: discard = cond_true_i;
                cpu_fmt_pkg::CLS_SKIP: begin
                    discard = cond_true_i;
                    skipf = cond_true_i;
                end
                default: ;
            endcase
        end
    endtask
    // stop pushing and wait, bounded, until every note is consumed
    task drain();
        push_i <= 1'b0;
        for (int t = 0; t < 300 && !(empty_o && exq.size() == 0); t++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        check("notes left", exq.size(), 0);
    endtask
    // watcher: each issue cycle takes the oldest note
    always @(posedge clk_i) begin
        if (rst_b_i && issue_valid_o === 1'b1) begin
            if (exq.size() == 0) check("extra issue", 1, 0);
            else begin
                e = exq.pop_front();
                check("nop", issue_nop_o, e.nop);
                check("second", issue_second_o, e.sec);
                if (e.sec) check("ext_word", ext_word_o, e.w);
                else if (!e.nop) begin
                    check("opcode", opcode_o, e.w[23:16]);
                    check("class", class_o, cls(e.w[23:16]));
                    // redirect shown with jumps, returns and taken branches only
                    check("pc_load", pc_load_o, cls(e.w[23:16]) == cpu_fmt_pkg::CLS_PC_JUMP ||
                        cls(e.w[23:16]) == cpu_fmt_pkg::CLS_RETURN ||
                        (cls(e.w[23:16]) == cpu_fmt_pkg::CLS_COND_BR && cond_true_i));
                    case (cls(e.w[23:16]))
                        cpu_fmt_pkg::CLS_THREE_OP: begin
                            check("base", base_source_operand_o, e.w[15:12]);
                            check("src", {second_mode_o, second_source_operand_o}, e.w[5:0]);
                            check("dest", {dest_mode_o, dest_operand_o}, e.w[11:6]);
                        end
                        cpu_fmt_pkg::CLS_FILE: begin
                            check("file", file_addr_o, e.w[12:0]);
                            check("default_working_reg", default_working_reg_o, !e.w[13]);
                        end
                        cpu_fmt_pkg::CLS_LIT_ARITH: begin
                            check("lit", literal_o, e.w[4:0]);
                            if (!e.w[16]) check("ldest", dest_operand_o, e.w[15:12]);
                        end
                        cpu_fmt_pkg::CLS_BIT: begin
                            check("bitreg", bit_from_reg_o, e.w[17]);
                            check("bitsel", bit_sel_o, e.w[17] ? 4'h0 :
                                (e.w[16] ? {e.w[15:13], e.w[0]} : e.w[15:12]));
                            if (e.w[16]) check("baddr", file_addr_o, {e.w[12:1], 1'b0});
                        end
                        default: ;
                    endcase
                end
            end
        end
    end
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    // main sequence: directed list in all condition/stall modes, then random words
    initial begin
        void'($urandom(32'h87b1));
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            cond_true_i <= k[0];
            slow_i <= k[1];
            @(posedge clk_i);
            foreach (prog[i]) push(prog[i]);
            foreach (tail[i]) push(tail[i]);
            drain();
        end
        for (int k = 0; k < 30; k++) begin
            cond_true_i <= 1'($urandom_range(1));
            slow_i <= 1'($urandom_range(1));
            @(posedge clk_i);
            for (int i = 0; i < 12; i++) begin
                w = 24'($urandom);
                if (pairw) w[23:16] = 8'h00;
                pairw = (cls(w[23:16]) == cpu_fmt_pkg::CLS_TWO_WORD);
                push(w);
            end
            drain();
        end
        results();
    end
endmodule
